// ==== logic/lcdis_top.sv ====
`timescale 1ns/1ps
module lcdis_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic serial_chip_select_pin,
	input wire logic addr_strap_low,
	input wire logic addr_strap_high,
	input wire logic [6:0] disp_addr,
	output logic [7:0] disp_data,
	output logic busy_flag,
	output logic [6:0] address_counter,
	output logic bus_width_select,
	output logic line_count_select,
	output logic font_select,
	output logic display_on,
	output logic cursor_on,
	output logic blink_on,
	output logic entry_increment,
	output logic entry_shift
);
	// ************************************************************
	// Line sampling and conditions
	// ************************************************************
	logic scl_q;
	logic sda_q;
	lcdis_pkg::lcdis_state_e st_q;
	lcdis_pkg::lcdis_state_e st_d;
	lcdis_pkg::lcdis_kind_e kind_q;
	lcdis_pkg::lcdis_kind_e kind_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic cont_q;
	logic cont_d;
	logic dcs_q;
	logic dcs_d;

	lcdis_byte_if bif();

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	wire start_cond = scl_q && scl_in && sda_q && !sda_in;
	wire stop_cond = scl_q && scl_in && !sda_q && sda_in;
	wire scl_rise = !scl_q && scl_in;
	wire scl_fall = scl_q && !scl_in;
	// Pin must sit low for the serial port to listen
	wire cs_ok = !serial_chip_select_pin;
	wire byte_done = (st_q == lcdis_pkg::ST_BITS) && scl_fall
		&& (cnt_q == lcdis_pkg::BIT_COUNT);
	wire [6:0] own_addr = {lcdis_pkg::ADDR_BASE, addr_strap_high, addr_strap_low};
	wire addr_hit = (sh_q[7:1] == own_addr) && !sh_q[lcdis_pkg::RW_BIT];

	// ************************************************************
	// Receive state machine
	// ************************************************************
	always_comb begin
		st_d = st_q;
		kind_d = kind_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		cont_d = cont_q;
		dcs_d = dcs_q;
		if (!cs_ok) begin
			st_d = lcdis_pkg::ST_IDLE;
		end else if (start_cond) begin
			st_d = lcdis_pkg::ST_BITS;
			kind_d = lcdis_pkg::KIND_ADDR;
			cnt_d = 4'h0;
		end else if (stop_cond) begin
			st_d = lcdis_pkg::ST_IDLE;
		end else begin
			case (st_q)
				lcdis_pkg::ST_BITS: begin
					if (scl_rise && cnt_q != lcdis_pkg::BIT_COUNT) begin
						sh_d = {sh_q[6:0], sda_in};
						cnt_d = cnt_q + 4'h1;
					end else if (byte_done) begin
						case (kind_q)
							lcdis_pkg::KIND_ADDR: begin
								if (addr_hit) begin
									st_d = lcdis_pkg::ST_ACK;
									kind_d = lcdis_pkg::KIND_CTRL;
								end else begin
									st_d = lcdis_pkg::ST_SKIP;
								end
							end
							lcdis_pkg::KIND_CTRL: begin
								cont_d = sh_q[lcdis_pkg::CTRL_CONT_BIT];
								dcs_d = sh_q[lcdis_pkg::CTRL_DCS_BIT];
								st_d = lcdis_pkg::ST_ACK;
								kind_d = lcdis_pkg::KIND_DATA;
							end
							default: begin
								st_d = lcdis_pkg::ST_HOLD;
								kind_d = cont_q ? lcdis_pkg::KIND_CTRL : lcdis_pkg::KIND_DATA;
							end
						endcase
					end
				end
				lcdis_pkg::ST_HOLD: begin
					if (bif.ready) begin
						st_d = lcdis_pkg::ST_ACK;
					end
				end
				lcdis_pkg::ST_ACK: begin
					if (scl_fall) begin
						st_d = lcdis_pkg::ST_BITS;
						cnt_d = 4'h0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= lcdis_pkg::ST_IDLE;
			kind_q <= lcdis_pkg::KIND_ADDR;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			cont_q <= 1'h0;
			dcs_q <= 1'h0;
		end else begin
			st_q <= st_d;
			kind_q <= kind_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			cont_q <= cont_d;
			dcs_q <= dcs_d;
		end
	end

	// ************************************************************
	// Pin drive and byte hand-off
	// ************************************************************
	// ack every accepted byte
	assign sda_oe = (st_q == lcdis_pkg::ST_ACK);
	assign sda_out = 1'h0;
	// never transmits, SDA pulled low only in the ack slot
	// Holding SCL low is the only flow control a write-only link has
	assign scl_oe = (st_q == lcdis_pkg::ST_HOLD);
	assign scl_out = 1'h0;

	assign bif.valid = (st_q == lcdis_pkg::ST_HOLD);
	assign bif.is_data = dcs_q;
	assign bif.byte_val = sh_q;

	lcdis_exec u_exec (
		.clock(clock),
		.rst_n(rst_n),
		.bif(bif),
		.disp_addr(disp_addr),
		.disp_data(disp_data),
		.busy_flag(busy_flag),
		.address_counter(address_counter),
		.bus_width_select(bus_width_select),
		.line_count_select(line_count_select),
		.font_select(font_select),
		.display_on(display_on),
		.cursor_on(cursor_on),
		.blink_on(blink_on),
		.entry_increment(entry_increment),
		.entry_shift(entry_shift)
	);

	// ************************************************************
	// Checks
	// ************************************************************
	a_start_addr: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && start_cond |=> st_q == lcdis_pkg::ST_BITS && kind_q == lcdis_pkg::KIND_ADDR
			&& cnt_q == 4'h0)
		else $error("start did not restart address reception");
	a_stop_idle: assert property (@(posedge clock) disable iff (!rst_n)
		stop_cond |=> st_q == lcdis_pkg::ST_IDLE ##1 !sda_oe && !scl_oe)
		else $error("stop did not return to idle");
	a_bit_count: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && !start_cond && !stop_cond && st_q == lcdis_pkg::ST_BITS && scl_rise
			&& cnt_q < lcdis_pkg::BIT_COUNT |=> cnt_q == $past(cnt_q) + 4'h1
			&& sh_q[0] == $past(sda_in))
		else $error("bit not taken on clock rise");
	a_addr_ack: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && !start_cond && !stop_cond && byte_done && kind_q == lcdis_pkg::KIND_ADDR
			&& addr_hit |=> sda_oe && !sda_out && kind_q == lcdis_pkg::KIND_CTRL)
		else $error("own address not acknowledged");
	a_miss_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && !start_cond && !stop_cond && byte_done && kind_q == lcdis_pkg::KIND_ADDR
			&& !addr_hit |=> (!sda_oe && !scl_oe)[*2])
		else $error("foreign address drove the bus");
	a_ack_hold: assert property (@(posedge clock) disable iff (!rst_n)
		sda_oe && scl_in && cs_ok && !start_cond && !stop_cond |=> sda_oe)
		else $error("ack released during clock high");
	a_ctrl_flags: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && !start_cond && !stop_cond && byte_done && kind_q == lcdis_pkg::KIND_CTRL
			|=> cont_q == $past(sh_q[7]) && dcs_q == $past(sh_q[6]))
		else $error("control flags not latched");
	a_data_only: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && !start_cond && !stop_cond && byte_done && kind_q == lcdis_pkg::KIND_DATA
			&& !cont_q |=> kind_q == lcdis_pkg::KIND_DATA && bif.valid)
		else $error("control byte expected after final control");
	a_stall_hold: assert property (@(posedge clock) disable iff (!rst_n)
		bif.valid && !bif.ready && cs_ok |=> scl_oe && bif.valid && $stable(bif.byte_val))
		else $error("byte dropped while controller busy");

	// ************************************************************
	// Byte framing and routing checks
	// ************************************************************
	a_cs_idle: assert property (@(posedge clock) disable iff (!rst_n)
		!cs_ok |=> st_q == lcdis_pkg::ST_IDLE && !sda_oe
			&& !scl_oe)
		else $error("deselected port still active");
	a_ack_release: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && st_q == lcdis_pkg::ST_ACK && scl_fall
			|=> st_q == lcdis_pkg::ST_BITS && !sda_oe && cnt_q == 4'h0)
		else $error("ack not released after its pulse");
	a_hold_ack: assert property (@(posedge clock) disable iff (!rst_n)
		bif.valid && bif.ready && cs_ok
			|=> sda_oe && !scl_oe && !bif.valid)
		else $error("taken byte not acknowledged");
	a_miss_skip: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && !start_cond && !stop_cond && st_q == lcdis_pkg::ST_SKIP
			|=> st_q == lcdis_pkg::ST_SKIP && !sda_oe)
		else $error("ignored transfer picked up again");
	a_read_nack: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && !start_cond && !stop_cond && byte_done && kind_q == lcdis_pkg::KIND_ADDR
			&& sh_q[lcdis_pkg::RW_BIT] |=> !sda_oe && st_q == lcdis_pkg::ST_SKIP)
		else $error("read request acknowledged");
	a_data_moves: assert property (@(posedge clock) disable iff (!rst_n)
		bif.valid && bif.ready && bif.is_data
			|=> address_counter != $past(address_counter))
		else $error("pointer not updated after data byte");
	a_ctrl_ack: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && !start_cond && !stop_cond && byte_done && kind_q == lcdis_pkg::KIND_CTRL
			|=> sda_oe && kind_q == lcdis_pkg::KIND_DATA)
		else $error("control byte not acknowledged");
	a_strap_match: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && !start_cond && !stop_cond && byte_done && kind_q == lcdis_pkg::KIND_ADDR
			&& sh_q[7:3] == lcdis_pkg::ADDR_BASE
			&& sh_q[2:1] == {addr_strap_high, addr_strap_low} && !sh_q[0] |=> sda_oe)
		else $error("strapped address not answered");
	a_no_extra: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && !start_cond && !stop_cond && st_q == lcdis_pkg::ST_BITS && !scl_rise
			|=> $stable(sh_q) && $stable(cnt_q))
		else $error("bit taken without clock rise");
	a_ctrl_next: assert property (@(posedge clock) disable iff (!rst_n)
		cs_ok && !start_cond && !stop_cond && byte_done && kind_q == lcdis_pkg::KIND_DATA
			&& cont_q |=> kind_q == lcdis_pkg::KIND_CTRL && st_q == lcdis_pkg::ST_HOLD)
		else $error("control byte not expected after paired data");
endmodule : lcdis_top

// ==== include/lcdis_pkg.sv ====
package lcdis_pkg;
	// ************************************************************
	// Serial slave constants
	// ************************************************************
	localparam logic [4:0] ADDR_BASE = 5'h0f;
	localparam logic [3:0] BIT_COUNT = 4'h8;
	localparam int RW_BIT = 0;
	localparam int CTRL_CONT_BIT = 7;
	localparam int CTRL_DCS_BIT = 6;
	// ************************************************************
	// Controller constants
	// ************************************************************
	localparam logic [7:0] CLEAR_CHAR = 8'h20;
	localparam logic [6:0] AC_LAST = 7'h7f;
	localparam int RAM_DEPTH = 128;
	localparam int CG_DEPTH = 64;
	localparam int FS_BW_BIT = 4;
	localparam int FS_LINES_BIT = 3;
	localparam int FS_FONT_BIT = 2;
	localparam int DC_DISP_BIT = 2;
	localparam int DC_CUR_BIT = 1;
	localparam int DC_BLINK_BIT = 0;
	localparam int EM_INC_BIT = 1;
	localparam int EM_SHIFT_BIT = 0;
	localparam int SH_DISP_BIT = 3;
	localparam int SH_RIGHT_BIT = 2;
	localparam logic RST_BUS_WIDTH = 1'h1;
	localparam logic RST_LINES = 1'h0;
	localparam logic RST_FONT = 1'h0;
	localparam logic RST_DISPLAY = 1'h0;
	localparam logic RST_CURSOR = 1'h0;
	localparam logic RST_BLINK = 1'h0;
	localparam logic RST_INC = 1'h1;
	localparam logic RST_SHIFT = 1'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_BITS = 3'h1,
		ST_HOLD = 3'h2,
		ST_ACK = 3'h3,
		ST_SKIP = 3'h4
	} lcdis_state_e;

	typedef enum logic [1:0] {
		KIND_ADDR = 2'h0,
		KIND_CTRL = 2'h1,
		KIND_DATA = 2'h2
	} lcdis_kind_e;

	typedef enum logic [1:0] {
		EX_CLEAR = 2'h0,
		EX_READY = 2'h1
	} lcdis_exec_e;
endpackage : lcdis_pkg

// ==== include/lcdis_byte_if.sv ====
`timescale 1ns/1ps
interface lcdis_byte_if;
	logic valid;
	logic ready;
	logic is_data;
	logic [7:0] byte_val;

	modport src (output valid, output is_data, output byte_val, input ready);
	modport dst (input valid, input is_data, input byte_val, output ready);
endinterface : lcdis_byte_if

// ==== logic/lcdis_exec.sv ====
`timescale 1ns/1ps
module lcdis_exec (
	input wire logic clock,
	input wire logic rst_n,
	lcdis_byte_if.dst bif,
	input wire logic [6:0] disp_addr,
	output logic [7:0] disp_data,
	output logic busy_flag,
	output logic [6:0] address_counter,
	output logic bus_width_select,
	output logic line_count_select,
	output logic font_select,
	output logic display_on,
	output logic cursor_on,
	output logic blink_on,
	output logic entry_increment,
	output logic entry_shift
);
	lcdis_pkg::lcdis_exec_e st_q;
	logic [6:0] clr_q;
	logic [6:0] ac_q;
	logic cg_sel_q;
	logic [7:0] display_text_ram [lcdis_pkg::RAM_DEPTH];
	logic [7:0] cgram [lcdis_pkg::CG_DEPTH];
	logic [7:0] disp_q;

	function automatic logic [6:0] lcdis_step(input logic [6:0] a, input logic up);
		lcdis_step = up ? a + 7'h01 : a - 7'h01;
	endfunction : lcdis_step

	wire clearing = (st_q == lcdis_pkg::EX_CLEAR);
	wire accept = bif.valid && bif.ready;
	wire [7:0] b = bif.byte_val;
	wire is_clear = accept && !bif.is_data && (b == 8'h01);
	wire ram_we = clearing || (accept && bif.is_data && !cg_sel_q);
	wire [6:0] ram_wa = clearing ? clr_q : ac_q;
	wire [7:0] ram_wd = clearing ? lcdis_pkg::CLEAR_CHAR : b;
	wire cg_we = accept && bif.is_data && cg_sel_q;

	assign bif.ready = !clearing;
	assign busy_flag = clearing;
	assign address_counter = ac_q;
	assign disp_data = disp_q;

	always_ff @(posedge clock) begin
		if (ram_we) begin
			display_text_ram[ram_wa] <= ram_wd;
		end
		if (cg_we) begin
			cgram[ac_q[5:0]] <= b;
		end
		disp_q <= display_text_ram[disp_addr];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= lcdis_pkg::EX_CLEAR;
			clr_q <= 7'h00;
		end else if (is_clear) begin
			st_q <= lcdis_pkg::EX_CLEAR;
			clr_q <= 7'h00;
		end else if (clearing) begin
			clr_q <= clr_q + 7'h01;
			if (clr_q == lcdis_pkg::AC_LAST) begin
				st_q <= lcdis_pkg::EX_READY;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ac_q <= 7'h00;
			cg_sel_q <= 1'h0;
			bus_width_select <= lcdis_pkg::RST_BUS_WIDTH;
			line_count_select <= lcdis_pkg::RST_LINES;
			font_select <= lcdis_pkg::RST_FONT;
			display_on <= lcdis_pkg::RST_DISPLAY;
			cursor_on <= lcdis_pkg::RST_CURSOR;
			blink_on <= lcdis_pkg::RST_BLINK;
			entry_increment <= lcdis_pkg::RST_INC;
			entry_shift <= lcdis_pkg::RST_SHIFT;
		end else if (accept && bif.is_data) begin
			ac_q <= lcdis_step(ac_q, entry_increment);
		end else if (accept) begin
			casez (b)
				8'b1???????: begin
					ac_q <= b[6:0];
					cg_sel_q <= 1'h0;
				end
				8'b01??????: begin
					ac_q <= {1'h0, b[5:0]};
					cg_sel_q <= 1'h1;
				end
				8'b001?????: begin
					bus_width_select <= b[lcdis_pkg::FS_BW_BIT];
					line_count_select <= b[lcdis_pkg::FS_LINES_BIT];
					font_select <= b[lcdis_pkg::FS_FONT_BIT];
				end
				8'b0001????: begin
					// Display shift has no state here, only the cursor moves
					if (!b[lcdis_pkg::SH_DISP_BIT]) begin
						ac_q <= lcdis_step(ac_q, b[lcdis_pkg::SH_RIGHT_BIT]);
					end
				end
				8'b00001???: begin
					display_on <= b[lcdis_pkg::DC_DISP_BIT];
					cursor_on <= b[lcdis_pkg::DC_CUR_BIT];
					blink_on <= b[lcdis_pkg::DC_BLINK_BIT];
				end
				8'b000001??: begin
					entry_increment <= b[lcdis_pkg::EM_INC_BIT];
					entry_shift <= b[lcdis_pkg::EM_SHIFT_BIT];
				end
				8'b0000001?: begin
					ac_q <= 7'h00;
					cg_sel_q <= 1'h0;
				end
				8'b00000001: begin
					ac_q <= 7'h00;
					cg_sel_q <= 1'h0;
				end
				default: begin
				end
			endcase
		end
	end

	a_data_step: assert property (@(posedge clock) disable iff (!rst_n)
		accept && bif.is_data && entry_increment |=> address_counter == $past(ac_q) + 7'h01)
		else $error("address counter did not step after data write");
	a_init_busy: assert property (@(posedge clock) disable iff (!rst_n)
		clearing && clr_q != lcdis_pkg::AC_LAST |=> busy_flag && !bif.ready)
		else $error("busy dropped before clear finished");
	a_clear_fill: assert property (@(posedge clock) disable iff (!rst_n)
		clearing |=> display_text_ram[$past(clr_q)] == lcdis_pkg::CLEAR_CHAR)
		else $error("clear did not write blank");
	a_func_set: assert property (@(posedge clock) disable iff (!rst_n)
		accept && !bif.is_data && b[7:5] == 3'h1 |=> bus_width_select == $past(b[4]))
		else $error("function set not applied");
endmodule : lcdis_exec

// ==== bench/lcdis_master.sv ====
`timescale 1ns/1ps
module lcdis_master (
	input wire logic clock,
	input wire logic scl_wire,
	input wire logic sda_wire,
	output logic scl_low,
	output logic sda_low
);
	// ************************************************************
	// Two-wire bus master
	// ************************************************************
	int timeouts = 0;

	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	task automatic half();
		repeat (4) @(posedge clock);
	endtask : half

	task automatic rise_scl();
		int n;
		n = 0;
		scl_low <= 1'b0;
		@(posedge clock);
		while (scl_wire !== 1'b1 && n < 400) begin
			n++;
			@(posedge clock);
		end
		if (n >= 400) begin
			timeouts++;
		end
		half();
	endtask : rise_scl

	// data moves only while clock low
	task automatic put_bit(input logic b, output logic got);
		sda_low <= ~b;
		half();
		rise_scl();
		got = sda_wire;
		scl_low <= 1'b1;
		half();
	endtask : put_bit

	task automatic start();
		sda_low <= 1'b0;
		half();
		rise_scl();
		sda_low <= 1'b1;
		half();
		scl_low <= 1'b1;
		half();
	endtask : start

	task automatic stop();
		sda_low <= 1'b1;
		half();
		rise_scl();
		sda_low <= 1'b0;
		half();
	endtask : stop

	// eight bits then released ack slot
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic got;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i], got);
		end
		put_bit(1'b1, got);
		ack = ~got;
	endtask : send_byte
endmodule : lcdis_master

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	typedef struct {logic sh; logic sl; logic [7:0] ab; logic ack;} lcdis_row_s;
	// Strap pairs against every reserved address, a read and a stranger
	lcdis_row_s rows[8] = '{'{0, 0, 8'h78, 1}, '{0, 1, 8'h7a, 1}, '{1, 0, 8'h7c, 1},
		'{1, 1, 8'h7e, 1}, '{0, 0, 8'h7a, 0}, '{1, 1, 8'h78, 0}, '{0, 0, 8'h79, 0},
		'{0, 0, 8'h38, 0}};
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic cs = 1'b0;
	logic sh = 1'b0;
	logic sl = 1'b0;
	logic [6:0] disp_addr = 7'h00;
	logic scl_low, sda_low, scl_oe, sda_oe, got;
	logic scl_out, sda_out;
	logic [7:0] disp_data;
	logic [6:0] ac;
	logic busy, bw, lines, font, d_on, c_on, b_on, inc, shf;
	int miscompares = 0;
	int n_checks = 0;
	int n;
	// Pull-ups: a line is high unless someone pulls it low
	wire scl_wire = ~(scl_low | (scl_oe & ~scl_out));
	wire sda_wire = ~(sda_low | (sda_oe & ~sda_out));

	always #20 clock = ~clock;

	lcdis_master mst (.clock(clock), .scl_wire(scl_wire), .sda_wire(sda_wire),
		.scl_low(scl_low), .sda_low(sda_low));

	lcdis_top dut (.clock(clock), .rst_n(rst_n), .scl_in(scl_wire), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
		.serial_chip_select_pin(cs), .addr_strap_low(sl), .addr_strap_high(sh),
		.disp_addr(disp_addr), .disp_data(disp_data), .busy_flag(busy),
		.address_counter(ac), .bus_width_select(bw), .line_count_select(lines),
		.font_select(font), .display_on(d_on), .cursor_on(c_on), .blink_on(b_on),
		.entry_increment(inc), .entry_shift(shf));

	// ************************************************************
	// Checking helpers
	// ************************************************************
	task automatic cmp_bit(input logic g, input logic e, input string what);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: %s got %b want %b", $time, what, g, e);
		end
	endtask : cmp_bit

	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e, input string what);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
		end
	endtask : cmp_byte

	task automatic finish_test();
		miscompares += mst.timeouts;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	task automatic send(input logic [7:0] b, input logic e);
		mst.send_byte(b, got);
		if (mst.timeouts != 0) begin
			miscompares++;
			finish_test();
		end
		cmp_bit(got, e, "ack");
	endtask : send

	task automatic check_ram(input logic [6:0] a, input logic [7:0] e);
		@(posedge clock);
		disp_addr <= a;
		repeat (3) @(posedge clock);
		#1;
		cmp_byte(disp_data, e, "ram");
	endtask : check_ram

	// Busy can only end by itself; the bound stands in for a hang
	task automatic wait_idle();
		n = 0;
		while (busy !== 1'b0 && n < 300) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n >= 300) begin
			miscompares++;
			finish_test();
		end
	endtask : wait_idle

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		#1;
		cmp_bit(busy, 1'b1, "busy");
		cmp_byte({bw, lines, font, d_on, c_on, b_on, inc, shf}, 8'h82, "defaults");
		cmp_byte({1'b0, ac}, 8'h00, "ac");
		wait_idle();
		cmp_bit(n >= 120 && n <= 136, 1'b1, "busy length");
		for (int a = 0; a < 128; a += 9) begin
			check_ram(a[6:0], 8'h20);
		end
		foreach (rows[i]) begin
			@(posedge clock);
			sh <= rows[i].sh;
			sl <= rows[i].sl;
			mst.start();
			send(rows[i].ab, rows[i].ack);
			mst.stop();
		end
		@(posedge clock);
		sh <= 1'b0;
		sl <= 1'b0;
		mst.start();
		send(8'h78, 1'b1);
		send(8'h40, 1'b1);
		send(8'h41, 1'b1);
		send(8'h80, 1'b1);
		mst.stop();
		check_ram(7'h00, 8'h41);
		check_ram(7'h01, 8'h80);
		cmp_byte({1'b0, ac}, 8'h02, "ac");
		mst.start();
		send(8'h78, 1'b1);
		send(8'h80, 1'b1);
		send(8'h3c, 1'b1);
		send(8'hc0, 1'b1);
		send(8'h55, 1'b1);
		send(8'h00, 1'b1);
		send(8'h0f, 1'b1);
		send(8'h04, 1'b1);
		send(8'h8a, 1'b1);
		mst.stop();
		cmp_byte({bw, lines, font, d_on, c_on, b_on, inc, shf}, 8'hfc, "settings");
		cmp_byte({1'b0, ac}, 8'h0a, "ac");
		check_ram(7'h02, 8'h55);
		mst.start();
		send(8'h78, 1'b1);
		send(8'h40, 1'b1);
		for (int i = 0; i < 3; i++) begin
			mst.put_bit(1'b1, got);
		end
		mst.start();
		send(8'h78, 1'b1);
		send(8'h40, 1'b1);
		send(8'h66, 1'b1);
		mst.stop();
		check_ram(7'h0a, 8'h66);
		cmp_byte({1'b0, ac}, 8'h09, "ac");
		mst.start();
		send(8'h78, 1'b1);
		send(8'h00, 1'b1);
		send(8'h01, 1'b1);
		send(8'h8c, 1'b1);
		mst.stop();
		wait_idle();
		check_ram(7'h0a, 8'h20);
		cmp_byte({1'b0, ac}, 8'h0c, "ac");
		cmp_bit(inc, 1'b0, "inc");
		@(posedge clock);
		cs <= 1'b1;
		mst.start();
		send(8'h78, 1'b0);
		mst.stop();
		finish_test();
	end
endmodule : tb_top
